/* ioa_defs.svh */
// constant definitions for the indexed operand addressing block
`ifndef IOA_DEFS_SVH
`define IOA_DEFS_SVH
`define IOA_ADDR_W 32
`define IOA_WORD_W 16
`define IOA_PTR_CNT 16
`define IOA_PTR_IDX_W 4
`define IOA_OFS_W 12
`define IOA_STEP_ONE 32'h00000001
`define IOA_STEP_TWO 32'h00000002
`define IOA_SIGN_BIT 15
`define IOA_BCD_DIGIT_MAX 4'h9
`define IOA_NUL_BYTE 8'h00
`define IOA_NUL_WORD 16'h0000
`define IOA_ADDR_ZERO 32'h00000000
`define IOA_OFS_SIGN 11
`define IOA_OFS_EXT_W 20
`define IOA_NIB_W 4
`define IOA_NIB_CNT 8
`define IOA_LOW_NIB 3:0
`define IOA_HI_HALF 31:16
`define IOA_SIGN_SPAN 31:15
`define IOA_HALF_ZERO 16'h0000
`define IOA_FMT_HEX 2'h0
`define IOA_FMT_SDEC 2'h1
`define IOA_FMT_UDEC 2'h2
`define IOA_FMT_BCD 2'h3
`endif

/* ioa_pkg.sv */
// types for the indexed operand addressing block
package ioa_pkg;
  // operand addressing modes
  typedef enum logic [2:0] {
    IOA_LOAD_ADDR = 3'b000,
    IOA_LOAD_TIMER_ADDR = 3'b001,
    IOA_PLAIN = 3'b010,
    IOA_CONST_OFS = 3'b011,
    IOA_REG_OFS = 3'b100,
    IOA_POST_INC = 3'b101,
    IOA_PRE_DEC = 3'b110,
    IOA_CONST_CHECK = 3'b111
  } ioa_mode_t;
  // request from the instruction decoder
  typedef struct packed {
    logic valid;
    ioa_mode_t mode;
    logic [3:0] ptrIdx;
    logic stepTwo;
    logic [11:0] constOfs;
    logic [31:0] offsetReg;
    logic [31:0] loadAddr;
    logic [31:0] constVal;
    logic constWide;
    logic [1:0] constFmt;
  } ioa_req_t;
  // answer toward the memory access path
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic constOk;
  } ioa_rsp_t;
  // text packing request and answer
  typedef struct packed {
    logic valid;
    logic [7:0] ch;
    logic last;
  } ioa_chr_t;
  typedef struct packed {
    logic valid;
    logic [15:0] word;
  } ioa_txt_t;
endpackage

/* ioa_text_packer.sv */
// packs a character stream into words, terminating with nulls
`timescale 1ns/1ps
module ioa_text_packer
  import ioa_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire ioa_chr_t chrIn,
  output ioa_txt_t wordOut
);
`include "ioa_defs.svh"
  logic haveLow_reg; // a low byte waits for its partner
  logic [7:0] lowByte_reg; // the waiting low byte
  logic padPending_reg; // even count: a null word still owed
  ioa_txt_t out_reg; // registered output word

  // first char fills the low byte, second the high byte
  always_ff @(posedge clk) begin
    if (reset) begin
      haveLow_reg <= 1'b0;
      lowByte_reg <= `IOA_NUL_BYTE;
      padPending_reg <= 1'b0;
      out_reg <= '0;
    end else begin
      out_reg.valid <= 1'b0;
      if (padPending_reg) begin
        // null word after an even-length string
        out_reg.valid <= 1'b1;
        out_reg.word <= `IOA_NUL_WORD;
        padPending_reg <= 1'b0;
      end else if (chrIn.valid) begin
        if (!haveLow_reg) begin
          if (chrIn.last) begin
            // odd count: null goes in the upper byte
            out_reg.valid <= 1'b1;
            out_reg.word <= {`IOA_NUL_BYTE, chrIn.ch};
          end else begin
            haveLow_reg <= 1'b1;
            lowByte_reg <= chrIn.ch;
          end
        end else begin
          out_reg.valid <= 1'b1;
          out_reg.word <= {chrIn.ch, lowByte_reg};
          haveLow_reg <= 1'b0;
          padPending_reg <= chrIn.last;
        end
      end
    end
  end

  assign wordOut = out_reg;

  a_odd_pad: assert property (@(posedge clk) disable iff (reset)
    (chrIn.valid && chrIn.last && !haveLow_reg && !padPending_reg)
      |=> (wordOut.valid && wordOut.word[15:8] == `IOA_NUL_BYTE))
    else $error("odd string lacks null upper byte");
  a_even_pad: assert property (@(posedge clk) disable iff (reset)
    (chrIn.valid && chrIn.last && haveLow_reg && !padPending_reg)
      |=> ##1 (wordOut.valid && wordOut.word == `IOA_NUL_WORD))
    else $error("even string lacks null word");
endmodule // ioa_text_packer

/* ioa_operand_addr.sv */
// index register file and operand address resolution
`timescale 1ns/1ps
module ioa_operand_addr
  import ioa_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire ioa_req_t req,
  input wire logic instrError,
  input wire ioa_chr_t chrIn,
  output ioa_rsp_t rsp,
  output logic errSeen,
  output ioa_txt_t wordOut
);
`include "ioa_defs.svh"
  // sixteen pointer registers
  logic [31:0] ptr_reg [0:15];
  logic [31:0] ptrSel; // selected pointer value
  logic [31:0] ofsExt; // sign-extended constant offset
  logic [31:0] addr_next; // resolved operand address
  logic [31:0] step; // auto step size
  logic ptrWrite; // pointer written this cycle
  logic [31:0] ptrWrData; // value written
  logic constOk_next; // constant range check
  logic hiClear; // upper half of the constant is clear
  logic signFill; // every bit above the word sign copies it
  ioa_rsp_t rsp_reg; // registered answer
  logic errSeen_reg; // registered error echo

  // bcd check of one nibble
  function automatic logic bcdNib(input logic [3:0] n);
    bcdNib = (n <= `IOA_BCD_DIGIT_MAX);
  endfunction

  // offset as two's complement, sign at the top bit
  assign ofsExt = {{`IOA_OFS_EXT_W{req.constOfs[`IOA_OFS_SIGN]}}, req.constOfs};
  assign ptrSel = ptr_reg[req.ptrIdx];
  assign step = req.stepTwo ? `IOA_STEP_TWO : `IOA_STEP_ONE;
  // narrow data must fit the low word; signed narrow data is sign-extended
  assign hiClear = (req.constVal[`IOA_HI_HALF] == `IOA_HALF_ZERO);
  assign signFill = (&req.constVal[`IOA_SIGN_SPAN]) ||
    (~|req.constVal[`IOA_SIGN_SPAN]);

  // address resolution and pointer write decision
  always_comb begin
    addr_next = ptrSel;
    ptrWrite = 1'b0;
    ptrWrData = ptrSel;
    case (req.mode)
      IOA_LOAD_ADDR: begin
        addr_next = req.loadAddr;
        ptrWrite = req.valid;
        ptrWrData = req.loadAddr;
      end
      IOA_LOAD_TIMER_ADDR: begin
        addr_next = req.loadAddr;
        ptrWrite = req.valid;
        ptrWrData = req.loadAddr;
      end
      IOA_PLAIN: addr_next = ptrSel;
      IOA_CONST_OFS: addr_next = ptrSel + ofsExt;
      IOA_REG_OFS: addr_next = ptrSel + req.offsetReg;
      IOA_POST_INC: begin
        // address is the old value, pointer moves after
        addr_next = ptrSel;
        ptrWrite = req.valid;
        ptrWrData = ptrSel + step;
      end
      IOA_PRE_DEC: begin
        addr_next = ptrSel - step;
        ptrWrite = req.valid;
        ptrWrData = ptrSel - step;
      end
      IOA_CONST_CHECK: addr_next = `IOA_ADDR_ZERO;
      default: addr_next = ptrSel;
    endcase
  end

  // constant format check: hex, signed dec, unsigned dec, bcd
  always_comb begin
    constOk_next = 1'b1;
    case (req.constFmt)
      `IOA_FMT_HEX: constOk_next = req.constWide || hiClear;
      `IOA_FMT_SDEC: constOk_next = req.constWide || signFill;
      `IOA_FMT_UDEC: constOk_next = req.constWide || hiClear;
      `IOA_FMT_BCD: begin
        // every nibble must hold a decimal digit
        for (int n = 0; n < `IOA_NIB_CNT; n++) begin
          if (!bcdNib(req.constVal[n * `IOA_NIB_W +: `IOA_NIB_W])) begin
            constOk_next = 1'b0;
          end
        end
        // narrow data stops at four digits
        if (!req.constWide && !hiClear) begin
          constOk_next = 1'b0;
        end
      end
      default: constOk_next = 1'b0;
    endcase
  end

  // pointer file; error input deliberately not consulted
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < `IOA_PTR_CNT; i++) begin
        ptr_reg[i] <= `IOA_ADDR_ZERO;
      end
    end else if (ptrWrite) begin
      ptr_reg[req.ptrIdx] <= ptrWrData;
    end
  end

  // answer register
  always_ff @(posedge clk) begin
    if (reset) begin
      rsp_reg <= '0;
      errSeen_reg <= 1'b0;
    end else begin
      rsp_reg.valid <= req.valid;
      rsp_reg.addr <= addr_next;
      rsp_reg.constOk <= constOk_next;
      errSeen_reg <= req.valid && instrError;
    end
  end

  assign rsp = rsp_reg;
  assign errSeen = errSeen_reg;

  // text packing path
  ioa_text_packer u_packer (
    .clk(clk),
    .reset(reset),
    .chrIn(chrIn),
    .wordOut(wordOut)
  );

  a_load_ptr: assert property (@(posedge clk) disable iff (reset)
    (req.valid && req.mode == IOA_LOAD_ADDR)
      |=> ptr_reg[$past(req.ptrIdx)] == $past(req.loadAddr))
    else $error("pointer load lost");
  a_timer_load: assert property (@(posedge clk) disable iff (reset)
    (req.valid && req.mode == IOA_LOAD_TIMER_ADDR)
      |=> ptr_reg[$past(req.ptrIdx)] == $past(req.loadAddr))
    else $error("timer pointer load lost");
  a_plain_addr: assert property (@(posedge clk) disable iff (reset)
    (req.valid && req.mode == IOA_PLAIN) |=> rsp.addr == $past(ptrSel))
    else $error("plain address wrong");
  a_const_ofs: assert property (@(posedge clk) disable iff (reset)
    (req.valid && req.mode == IOA_CONST_OFS)
      |=> $signed(rsp.addr - $past(ptrSel)) == $signed($past(req.constOfs)))
    else $error("constant offset wrong");
  a_reg_ofs: assert property (@(posedge clk) disable iff (reset)
    (req.valid && req.mode == IOA_REG_OFS)
      |=> rsp.addr == $past(ptrSel) + $past(req.offsetReg))
    else $error("register offset wrong");
  a_post_inc: assert property (@(posedge clk) disable iff (reset)
    (req.valid && req.mode == IOA_POST_INC && req.stepTwo)
      |=> (rsp.addr == $past(ptrSel)) &&
        (ptr_reg[$past(req.ptrIdx)] == $past(ptrSel) + `IOA_STEP_TWO))
    else $error("post increment wrong");
  a_pre_dec: assert property (@(posedge clk) disable iff (reset)
    (req.valid && req.mode == IOA_PRE_DEC && !req.stepTwo)
      |=> (rsp.addr == $past(ptrSel) - `IOA_STEP_ONE) &&
        (ptr_reg[$past(req.ptrIdx)] == rsp.addr))
    else $error("pre decrement wrong");
  a_err_step: assert property (@(posedge clk) disable iff (reset)
    (req.valid && instrError && req.mode == IOA_POST_INC)
      |=> ptr_reg[$past(req.ptrIdx)] != $past(ptrSel))
    else $error("step skipped on error");
  a_bcd_digit: assert property (@(posedge clk) disable iff (reset)
    (req.valid && req.constFmt == `IOA_FMT_BCD &&
      req.constVal[`IOA_LOW_NIB] > `IOA_BCD_DIGIT_MAX) |=> !rsp.constOk)
    else $error("bad bcd accepted");

  // the other step sizes and a decrement under error; each step lands once, in the answer cycle
  a_post_inc_one: assert property (@(posedge clk) disable iff (reset)
    (req.valid && req.mode == IOA_POST_INC && !req.stepTwo)
      |=> (rsp.addr == $past(ptrSel)) &&
        (ptr_reg[$past(req.ptrIdx)] == $past(ptrSel) + `IOA_STEP_ONE))
    else $error("post increment by one wrong");
  a_pre_dec_two: assert property (@(posedge clk) disable iff (reset)
    (req.valid && req.mode == IOA_PRE_DEC && req.stepTwo)
      |=> (rsp.addr == $past(ptrSel) - `IOA_STEP_TWO) &&
        (ptr_reg[$past(req.ptrIdx)] == rsp.addr))
    else $error("pre decrement by two wrong");
  a_err_dec: assert property (@(posedge clk) disable iff (reset)
    (req.valid && instrError && req.mode == IOA_PRE_DEC)
      |=> ptr_reg[$past(req.ptrIdx)] != $past(ptrSel))
    else $error("decrement skipped on error");

  // a pointer must not drift when no stepping or load instruction runs
  a_idle_hold: assert property (@(posedge clk) disable iff (reset)
    (!req.valid || req.mode inside {IOA_PLAIN, IOA_CONST_OFS, IOA_REG_OFS, IOA_CONST_CHECK})
      |=> ptr_reg[$past(req.ptrIdx)] == $past(ptrSel))
    else $error("pointer moved without a step");

  // one answer pulse per request, error echo in the same cycle
  a_rsp_pulse: assert property (@(posedge clk) disable iff (reset)
    1'b1 |=> rsp.valid == $past(req.valid))
    else $error("answer pulse wrong");
  a_err_echo: assert property (@(posedge clk) disable iff (reset)
    1'b1 |=> errSeen == $past(req.valid && instrError))
    else $error("error echo wrong");

  // constant ranges checked straight from the raw bits, not the helper flags
  a_hex_narrow: assert property (@(posedge clk) disable iff (reset)
    (req.valid && req.constFmt == `IOA_FMT_HEX && !req.constWide &&
      req.constVal[`IOA_HI_HALF] != `IOA_HALF_ZERO) |=> !rsp.constOk)
    else $error("wide hex accepted as narrow");
  a_sign_range: assert property (@(posedge clk) disable iff (reset)
    (req.valid && req.constFmt == `IOA_FMT_SDEC && !req.constWide &&
      (&req.constVal[`IOA_SIGN_SPAN])) |=> rsp.constOk)
    else $error("negative narrow constant refused");
endmodule // ioa_operand_addr

/* ioa_operand_addr_tb.sv */
// self-checking testbench for the operand addressing block
`timescale 1ns/1ps
module testbench;
  import ioa_pkg::*;
  logic clk = 1'b0; // 125 MHz execution clock
  logic reset = 1'b1; // synchronous, active high
  ioa_req_t req = '0; // decoder request
  logic instrError = 1'b0; // error flag of the current instruction
  ioa_chr_t chrIn = '0; // character stream
  ioa_rsp_t rsp; // resolved address
  logic errSeen; // registered error echo
  ioa_txt_t wordOut; // packed text words
  int err_count = 0; // mismatches
  int checks = 0; // comparisons made
  logic cWide = 1'b0; // constant width for the next check
  logic [1:0] cFmt = 2'h0; // constant format for the next check
  logic cOk = 1'b0; // expected range verdict
  logic [15:0] wq[$]; // words seen on the text path

  ioa_operand_addr i_ioa_operand_addr (.clk(clk), .reset(reset), .req(req),
    .instrError(instrError), .chrIn(chrIn), .rsp(rsp), .errSeen(errSeen), .wordOut(wordOut));

  // free-running clock
  always #4 clk = ~clk;

  // collect every text word; sampled at the edge so the value is settled
  always @(posedge clk) begin
    if (wordOut.valid === 1'b1) wq.push_back(wordOut.word);
  end

  // compare task for words and addresses
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // verdict and end of run
  task automatic test_done();
    $display("errors %0d checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // one request; the same operand feeds offset, register, load and constant fields
  task automatic op(ioa_mode_t m, logic [3:0] p, logic s2, logic [31:0] x, logic e,
                    logic [31:0] ea);
    @(posedge clk);
    req <= {1'b1, m, p, s2, x[11:0], x, x, x, cWide, cFmt};
    instrError <= e;
    @(posedge clk);
    req.valid <= 1'b0;
    instrError <= 1'b0;
    #1;
    // answer stands 1 ns after the edge that takes the request
    chk({31'h0, rsp.valid}, 32'h1);
    chk({31'h0, errSeen}, {31'h0, e});
    if (m != IOA_LOAD_ADDR && m != IOA_LOAD_TIMER_ADDR) chk(rsp.addr, ea);
    if (m == IOA_CONST_CHECK) chk({31'h0, rsp.constOk}, {31'h0, cOk});
    // the pulses must drop again once the request is gone
    @(posedge clk);
    #1;
    chk({31'h0, rsp.valid}, 32'h0);
    chk({31'h0, errSeen}, 32'h0);
  endtask

  // constant range check with a chosen width and format
  task automatic cc(logic [31:0] v, logic w, logic [1:0] f, logic ok);
    cWide = w;
    cFmt = f;
    cOk = ok;
    op(IOA_CONST_CHECK, 4'h0, 1'b0, v, 1'b0, 32'h0);
  endtask

  // send a string back to back and compare the two words that result
  task automatic txt(string s, logic [15:0] w0, logic [15:0] w1);
    wq.delete();
    for (int i = 0; i < s.len(); i++) begin
      @(posedge clk);
      chrIn <= {1'b1, s[i], i == s.len() - 1};
    end
    @(posedge clk);
    chrIn <= '0;
    // leaves the pad cycle idle and lets the null word land
    repeat (4) @(posedge clk);
    chk(wq.size(), 2);
    if (wq.size() == 2) begin
      chk({16'h0, wq[0]}, {16'h0, w0});
      chk({16'h0, wq[1]}, {16'h0, w1});
    end
  endtask

  // hang guard: bounded run length
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    test_done();
  end

  // pointers start clear, then loads and plain reads of the loaded pointers
  task automatic scen_load();
    op(IOA_PLAIN, 4'h0, 1'b0, 32'h0, 1'b0, 32'h0);
    op(IOA_LOAD_ADDR, 4'h3, 1'b0, 32'h00001000, 1'b0, 32'h0);
    op(IOA_LOAD_TIMER_ADDR, 4'hf, 1'b0, 32'h00008001, 1'b0, 32'h0);
    op(IOA_PLAIN, 4'h3, 1'b0, 32'h0, 1'b0, 32'h00001000);
    op(IOA_PLAIN, 4'hf, 1'b0, 32'h0, 1'b0, 32'h00008001);
  endtask

  // constant offsets at both range ends and a negative register offset
  task automatic scen_offsets();
    op(IOA_CONST_OFS, 4'h3, 1'b0, 32'h00000800, 1'b0, 32'h00000800);
    op(IOA_CONST_OFS, 4'h3, 1'b0, 32'h000007ff, 1'b0, 32'h000017ff);
    op(IOA_REG_OFS, 4'h3, 1'b0, 32'hffffcfc7, 1'b0, 32'hffffdfc7);
  endtask

  // post-increment and pre-decrement; some raise the error flag, which must not stop them
  task automatic scen_steps();
    op(IOA_POST_INC, 4'h3, 1'b1, 32'h0, 1'b1, 32'h00001000);
    op(IOA_PLAIN, 4'h3, 1'b0, 32'h0, 1'b0, 32'h00001002);
    op(IOA_POST_INC, 4'h3, 1'b0, 32'h0, 1'b0, 32'h00001002);
    op(IOA_PLAIN, 4'h3, 1'b0, 32'h0, 1'b0, 32'h00001003);
    op(IOA_PRE_DEC, 4'hf, 1'b1, 32'h0, 1'b1, 32'h00007fff);
    op(IOA_PRE_DEC, 4'hf, 1'b0, 32'h0, 1'b0, 32'h00007ffe);
    op(IOA_PLAIN, 4'hf, 1'b0, 32'h0, 1'b0, 32'h00007ffe);
  endtask

  // range checks for every constant format at both widths
  task automatic scen_constants();
    cc(32'h0000ffff, 1'b0, 2'h0, 1'b1);
    cc(32'h00010000, 1'b0, 2'h0, 1'b0);
    cc(32'hffffffff, 1'b1, 2'h0, 1'b1);
    cc(32'hffff8000, 1'b0, 2'h1, 1'b1);
    cc(32'h00008000, 1'b0, 2'h1, 1'b0);
    cc(32'hffffcfc7, 1'b0, 2'h1, 1'b1);
    cc(32'h80000000, 1'b1, 2'h1, 1'b1);
    cc(32'hffffffff, 1'b1, 2'h2, 1'b1);
    cc(32'h00010000, 1'b0, 2'h2, 1'b0);
    cc(32'h00009999, 1'b0, 2'h3, 1'b1);
    cc(32'h0000999a, 1'b0, 2'h3, 1'b0);
    cc(32'h00019999, 1'b0, 2'h3, 1'b0);
    cc(32'h99999999, 1'b1, 2'h3, 1'b1);
    cc(32'ha9999999, 1'b1, 2'h3, 1'b0);
  endtask

  // an even string, then an odd one whose last word carries a null upper byte
  task automatic scen_text();
    txt("AB", 16'h4241, 16'h0000);
    txt("ABC", 16'h4241, 16'h0043);
  endtask

  // reset in mid-run clears the outputs and every loaded pointer
  task automatic scen_reset();
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    #1;
    chk({31'h0, rsp.valid}, 32'h0);
    chk({16'h0, wordOut.word}, 32'h0);
    op(IOA_PLAIN, 4'h3, 1'b0, 32'h0, 1'b0, 32'h0);
    op(IOA_PLAIN, 4'hf, 1'b0, 32'h0, 1'b0, 32'h0);
  endtask

  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    scen_load();
    scen_offsets();
    scen_steps();
    scen_constants();
    scen_text();
    scen_reset();
    test_done();
  end
endmodule // testbench
